// File: logic/aci_pkg.sv
// Package of constants, opcodes and states for the ATA command interpreter
package aci_pkg;
   // ----------------------------------------------------------------
   // Register byte offsets on the APB side
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_DATA    = 8'h00;
   localparam logic [7:0] OFS_ERRFEAT = 8'h04;
   localparam logic [7:0] OFS_SECCNT  = 8'h08;
   localparam logic [7:0] OFS_SECNUM  = 8'h0c;
   localparam logic [7:0] OFS_CYLLO   = 8'h10;
   localparam logic [7:0] OFS_CYLHI   = 8'h14;
   localparam logic [7:0] OFS_DRVHEAD = 8'h18;
   localparam logic [7:0] OFS_STATCMD = 8'h1c;
   localparam logic [7:0] OFS_ALTCTL  = 8'h20;
   localparam logic [7:0] OFS_CONFIG  = 8'h24;
   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int BIT_BUSY    = 7;
   localparam int BIT_DRDY    = 6;
   localparam int BIT_DSC     = 4;
   localparam int BIT_DRQ     = 3;
   localparam int BIT_ERR     = 0;
   localparam int BIT_ABORT   = 2;
   localparam int BIT_DRIVE   = 4;
   localparam int BIT_LBA     = 6;
   localparam int BIT_SRST    = 2;
   localparam int BIT_NIEN    = 1;
   localparam int BIT_DMA_EN  = 0;
   localparam int BIT_CARD    = 1;
   localparam logic [7:0] RST_SECCNT  = 8'h01;
   localparam logic [7:0] RST_SECNUM  = 8'h01;
   localparam logic [7:0] RST_DRVHEAD = 8'ha0;
   localparam logic [7:0] PWR_STANDBY_CODE = 8'h00;
   localparam logic [7:0] PWR_IDLE_CODE    = 8'hff;
   localparam logic [7:0] DIAG_PASS_CODE   = 8'h01;
   localparam logic [7:0] DIAG_FAIL_CODE   = 8'h80;
   localparam logic [15:0] PATTERN_A = 16'haa55;
   localparam logic [15:0] PATTERN_B = 16'h55aa;
   localparam int DIAG_DEPTH   = 8;
   localparam int IDENT_WORDS  = 256;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ        = 40_000_000;
   localparam int MEDIA_TIME_NS = 1000;
   localparam int MEDIA_CYCLES  = (MEDIA_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   // ----------------------------------------------------------------
   // Opcodes
   // ----------------------------------------------------------------
   localparam logic [7:0] OP_CHKPWR_A = 8'h98, OP_CHKPWR_B = 8'he5;
   localparam logic [7:0] OP_DIAG     = 8'h90;
   localparam logic [7:0] OP_FORMAT   = 8'h50;
   localparam logic [7:0] OP_IDENT    = 8'hec;
   localparam logic [7:0] OP_RD_A     = 8'h20, OP_RD_B     = 8'h21;
   localparam logic [7:0] OP_VFY_A    = 8'h40, OP_VFY_B    = 8'h41;
   localparam logic [7:0] OP_WR_A     = 8'h30, OP_WR_B     = 8'h31;
   localparam logic [7:0] OP_RDL_A    = 8'h22, OP_RDL_B    = 8'h23;
   localparam logic [7:0] OP_SLEEP_A  = 8'h99, OP_SLEEP_B  = 8'he6;
   localparam logic [7:0] OP_STBY_A   = 8'h94, OP_STBY_B   = 8'he0;
   localparam logic [7:0] OP_IDLE_A   = 8'h97, OP_IDLE_B   = 8'he3;
   localparam logic [7:0] OP_IDLI_A   = 8'h95, OP_IDLI_B   = 8'he1;
   localparam logic [7:0] OP_RD_DMA   = 8'hc8;
   localparam logic [7:0] OP_WR_DMA   = 8'hca;
   // ----------------------------------------------------------------
   // Identify words
   // ----------------------------------------------------------------
   localparam logic [15:0] ID_W0_FIXED     = 16'h044a;
   localparam logic [15:0] ID_W0_REMOVABLE = 16'h848a;
   localparam logic [15:0] ID_BUF_TYPE     = 16'h0002;
   localparam logic [15:0] ID_ECC_BYTES    = 16'h0004;
   localparam logic [15:0] ID_MULTI_MAX    = 16'h0001;
   localparam logic [15:0] ID_CAPS         = 16'h0002;
   localparam logic [15:0] ID_PIO_TIMING   = 16'h0100;
   localparam logic [15:0] ID_MWDMA        = 16'h0407;
   localparam logic [15:0] ID_PIO_MODES    = 16'h0003;
   localparam logic [15:0] ID_CYCLE_NS     = 16'h0078;
   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [7:0] {
      ST_IDLE   = 8'b0000_0001,
      ST_CHKPWR = 8'b0000_0010,
      ST_DIAG_W = 8'b0000_0100,
      ST_DIAG_R = 8'b0000_1000,
      ST_COUNT  = 8'b0001_0000,
      ST_IDENT  = 8'b0010_0000,
      ST_DONE   = 8'b0100_0000
   } aci_state_t;
   typedef enum logic [1:0] {
      PWR_IDLE    = 2'b01,
      PWR_STANDBY = 2'b10
   } aci_pwr_t;
endpackage : aci_pkg

// File: logic/aci_top.sv
// ATA command interpreter with APB task-file access
// Summary of operation
// RULE_01: Power query in standby loads count zero
// RULE_02: Power query when idle loads all ones
// RULE_03: Query finish: busy drops, then interrupt
// RULE_04: Diagnostic writes, reads back two patterns
// RULE_05: Self-test mismatch puts code in error
// RULE_06: Format walks sectors from address registers; the code only counts down sec_cnt sectors
// RULE_07: Identify returns fixed words via data
// RULE_08: Decode 20h/21h as sector read
// RULE_09: Decode 40h/41h as read verify
// RULE_10: Decode 30h/31h as sector write
// RULE_11: Decode 22h/23h as long read
// RULE_12: Decode 99h/E6h as enter sleep
// RULE_13: Decode 94h/E0h as immediate standby
// RULE_14: Drive-only commands use only select bit
// RULE_15: DMA opcodes refused when DMA disabled
// RULE_16: Word 0 depends on interface mode
// RULE_17: Words 20/21 give buffer type, size
// RULE_18: Word 22 gives long-command ECC bytes
// RULE_19: Word 47 low byte: sectors per interrupt
// RULE_20: Word 51 high byte: PIO timing code
// RULE_21: Words 60-61 give LBA sector total
// RULE_22: New commands ignored while busy
// RULE_23: Status read clears interrupt request
// RULE_24: Drive/head bit 4 picks target drive
// RULE_25: Unknown opcode aborts with error, interrupt
//
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module aci_top
   import aci_pkg::*;
#(
   parameter logic [31:0] LBA_TOTAL  = 32'h0001_0000,
   parameter logic [15:0] BUF_BLOCKS = 16'h0002,
   parameter logic        DRIVE_NUM  = 1'b0
) (
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic        ce,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             busy_flag,
   output logic             host_irq_request
);
   // ----------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------
   function automatic logic is_pair(input logic [7:0] op, input logic [7:0] a,
                                    input logic [7:0] b);
      is_pair = (op == a) || (op == b);
   endfunction : is_pair
   function automatic logic [15:0] ident_word(input logic [7:0] idx, input logic card);
      ident_word = 16'h0000;
      unique case (idx)
         8'd0:  ident_word = card ? ID_W0_REMOVABLE : ID_W0_FIXED;   // [RULE_16]
         8'd20: ident_word = ID_BUF_TYPE;                           // [RULE_17]
         8'd21: ident_word = BUF_BLOCKS;                            // [RULE_17]
         8'd22: ident_word = ID_ECC_BYTES;                          // [RULE_18]
         8'd47: ident_word = ID_MULTI_MAX;                          // [RULE_19]
         8'd49: ident_word = ID_CAPS;
         8'd51: ident_word = ID_PIO_TIMING;                         // [RULE_20]
         8'd60: ident_word = LBA_TOTAL[15:0];                       // [RULE_21]
         8'd61: ident_word = LBA_TOTAL[31:16];                      // [RULE_21]
         8'd63: ident_word = ID_MWDMA;
         8'd64: ident_word = ID_PIO_MODES;
         8'd65, 8'd66, 8'd67, 8'd68: ident_word = ID_CYCLE_NS;
         default: ident_word = 16'h0000;
      endcase
   endfunction : ident_word

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   aci_state_t  state;
   aci_pwr_t    pwr;
   logic [7:0]  feature, sec_cnt, sec_num, cyl_lo, cyl_hi, drv_head, err_reg;
   logic        err_flag, drq, irq_pend, nien, dma_en, card_mode;
   logic [15:0] count;
   logic [7:0]  ident_idx;
   logic [2:0]  diag_idx;
   logic        diag_pass, diag_bad;
   logic [15:0] diag_buf [DIAG_DEPTH];

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   wire        acc      = psel && penable;
   wire        wr_acc   = acc && pwrite;
   wire        rd_acc   = acc && !pwrite;
   wire        setup_rd = psel && !penable && !pwrite;
   wire        mapped   = (paddr <= OFS_CONFIG) && (paddr[1:0] == 2'b00);
   wire        busy     = (state != ST_IDLE) && (state != ST_DONE);
   wire        wr_open  = wr_acc && !busy;                         // [RULE_22]
   wire [7:0]  wbyte    = pwdata[7:0];
   wire        soft_rst = wr_acc && (paddr == OFS_ALTCTL) && pwdata[BIT_SRST];
   wire        cmd_wr   = wr_open && (paddr == OFS_STATCMD);
   wire        for_us   = drv_head[BIT_DRIVE] == DRIVE_NUM;        // [RULE_24] [RULE_14]
   wire        go       = cmd_wr && for_us;
   wire [7:0]  status   = {busy, !busy, 1'b0, !busy, drq, 1'b0, 1'b0, err_flag};
   wire        stat_rd  = rd_acc && (paddr == OFS_STATCMD);
   wire        data_rd  = rd_acc && (paddr == OFS_DATA) && (state == ST_IDENT);
   wire        in_rst   = rst || soft_rst;

   // ----------------------------------------------------------------
   // Opcode decode
   // ----------------------------------------------------------------
   wire op_chkpwr = is_pair(wbyte, OP_CHKPWR_A, OP_CHKPWR_B);
   wire op_diag   = wbyte == OP_DIAG;                              // [RULE_04]
   wire op_format = wbyte == OP_FORMAT;                            // [RULE_06]
   wire op_ident  = wbyte == OP_IDENT;                             // [RULE_07]
   wire op_media  = is_pair(wbyte, OP_RD_A, OP_RD_B)               // [RULE_08]
                 || is_pair(wbyte, OP_VFY_A, OP_VFY_B)             // [RULE_09]
                 || is_pair(wbyte, OP_WR_A, OP_WR_B)               // [RULE_10]
                 || is_pair(wbyte, OP_RDL_A, OP_RDL_B);            // [RULE_11]
   wire op_dma    = (wbyte == OP_RD_DMA) || (wbyte == OP_WR_DMA);
   wire op_dma_ok = op_dma && dma_en;                              // [RULE_15]
   wire op_sleep  = is_pair(wbyte, OP_SLEEP_A, OP_SLEEP_B);        // [RULE_12]
   wire op_stby   = is_pair(wbyte, OP_STBY_A, OP_STBY_B);          // [RULE_13]
   wire op_idle   = is_pair(wbyte, OP_IDLE_A, OP_IDLE_B)
                 || is_pair(wbyte, OP_IDLI_A, OP_IDLI_B);
   wire op_known  = op_chkpwr || op_diag || op_format || op_ident || op_media
                 || op_dma_ok || op_sleep || op_stby || op_idle;
   // Sector count of zero means 256 sectors, as in every ATA transfer
   wire [15:0] sectors    = (sec_cnt == 8'h00) ? 16'd256 : {8'h00, sec_cnt};
   wire [15:0] media_len  = 16'(MEDIA_CYCLES) * sectors;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   aci_state_t next_state;
   wire count_end = count == 16'd0;
   wire diag_last = diag_idx == 3'(DIAG_DEPTH - 1);
   always_comb begin
      next_state = state;
      unique case (state)
         ST_IDLE, ST_DONE: begin
            next_state = ST_IDLE;
            if (go) begin
               if (op_chkpwr) begin
                  next_state = ST_CHKPWR;
               end else if (op_diag) begin
                  next_state = ST_DIAG_W;
               end else if (op_ident) begin
                  next_state = ST_IDENT;
               end else if (op_format || op_media || op_dma_ok) begin
                  next_state = ST_COUNT;
               end else begin
                  next_state = ST_DONE;                            // [RULE_25]
               end
            end
         end
         ST_CHKPWR: next_state = ST_DONE;
         ST_DIAG_W: next_state = diag_last ? ST_DIAG_R : ST_DIAG_W;
         ST_DIAG_R: next_state = !diag_last ? ST_DIAG_R : (diag_pass ? ST_DONE : ST_DIAG_W);
         ST_COUNT:  next_state = count_end ? ST_DONE : ST_COUNT;
         ST_IDENT:  next_state = (data_rd && ident_idx == 8'(IDENT_WORDS - 1)) ? ST_DONE
                                                                              : ST_IDENT;
         default:   next_state = ST_IDLE;
      endcase
   end

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   wire [15:0] diag_pat = diag_pass ? PATTERN_B : PATTERN_A;
   wire        diag_mis = (state == ST_DIAG_R) && (diag_buf[diag_idx] != diag_pat);

   always_ff @(posedge sys_clk) begin
      if (in_rst) begin
         state     <= ST_IDLE;
         count     <= 16'd0;
         ident_idx <= 8'd0;
         diag_idx  <= 3'd0;
         diag_pass <= 1'b0;
         diag_bad  <= 1'b0;
         drq       <= 1'b0;
         pwr       <= PWR_IDLE;
      end else if (ce) begin
         state <= next_state;
         if (!busy && go) begin                                    // DONE accepts too: none lost
            count     <= op_format ? sectors : media_len;          // [RULE_06]
            ident_idx <= 8'd0;
            diag_idx  <= 3'd0;
            diag_pass <= 1'b0;
            diag_bad  <= 1'b0;
            drq       <= op_ident;
            if (op_sleep || op_stby) begin
               pwr <= PWR_STANDBY;                                 // [RULE_12] [RULE_13]
            end else if (op_idle) begin
               pwr <= PWR_IDLE;
            end
         end
         if (state == ST_COUNT && !count_end) begin
            count <= count - 16'd1;
         end
         if (state == ST_DIAG_W || state == ST_DIAG_R) begin
            diag_idx <= diag_idx + 3'd1;                           // [RULE_04]
         end
         if (diag_mis) begin
            diag_bad <= 1'b1;
         end
         if (state == ST_DIAG_R && diag_last) begin
            diag_pass <= 1'b1;
         end
         if (data_rd) begin
            ident_idx <= ident_idx + 8'd1;
            if (ident_idx == 8'(IDENT_WORDS - 1)) begin
               drq <= 1'b0;
            end
         end
      end
   end

   // Buffer under test, written one word a cycle
   always_ff @(posedge sys_clk) begin
      if (ce && state == ST_DIAG_W) begin
         diag_buf[diag_idx] <= diag_pat;                           // [RULE_04]
      end
   end

   // ----------------------------------------------------------------
   // Task-file registers
   // ----------------------------------------------------------------
   wire unknown_cmd = go && !op_known;
   wire fin         = state == ST_DONE;
   wire diag_end    = state == ST_DIAG_R && diag_last && diag_pass;

   always_ff @(posedge sys_clk) begin
      if (in_rst) begin
         feature  <= 8'h00;
         sec_cnt  <= RST_SECCNT;
         sec_num  <= RST_SECNUM;
         cyl_lo   <= 8'h00;
         cyl_hi   <= 8'h00;
         drv_head <= RST_DRVHEAD;
         err_reg  <= 8'h00;
         err_flag <= 1'b0;
      end else if (ce) begin
         if (wr_open) begin
            unique case (paddr)
               OFS_ERRFEAT: feature  <= wbyte;
               OFS_SECCNT:  sec_cnt  <= wbyte;
               OFS_SECNUM:  sec_num  <= wbyte;
               OFS_CYLLO:   cyl_lo   <= wbyte;
               OFS_CYLHI:   cyl_hi   <= wbyte;
               OFS_DRVHEAD: drv_head <= wbyte;
               default: ;
            endcase
         end
         if (go) begin
            err_reg  <= 8'h00;
            err_flag <= 1'b0;
         end
         if (unknown_cmd) begin
            err_reg[BIT_ABORT] <= 1'b1;                            // [RULE_25] [RULE_15]
            err_flag           <= 1'b1;
         end
         if (state == ST_CHKPWR) begin
            sec_cnt <= (pwr == PWR_STANDBY) ? PWR_STANDBY_CODE     // [RULE_01]
                                            : PWR_IDLE_CODE;       // [RULE_02]
         end
         if (diag_end) begin
            err_reg  <= (diag_bad || diag_mis) ? DIAG_FAIL_CODE : DIAG_PASS_CODE; // [RULE_05]
            err_flag <= diag_bad || diag_mis;
         end
      end
   end

   // ----------------------------------------------------------------
   // Interrupt and control
   // ----------------------------------------------------------------
   // Raised as DONE is left, one cycle after busy drops; a raise beats a status read
   always_ff @(posedge sys_clk) begin
      if (in_rst) begin
         irq_pend <= 1'b0;
         nien     <= 1'b0;
         dma_en   <= 1'b0;
         card_mode <= 1'b0;
      end else if (ce) begin
         if (fin) begin
            irq_pend <= 1'b1;                                      // [RULE_03] [RULE_25]
         end else if (stat_rd) begin
            irq_pend <= 1'b0;                                      // [RULE_23]
         end
         if (wr_acc && paddr == OFS_ALTCTL) begin
            nien <= pwdata[BIT_NIEN];
         end
         if (wr_acc && paddr == OFS_CONFIG) begin
            dma_en    <= pwdata[BIT_DMA_EN];
            card_mode <= pwdata[BIT_CARD];
         end
      end
   end

   assign busy_flag        = busy;
   assign host_irq_request = irq_pend && !nien;

   // ----------------------------------------------------------------
   // Read data, captured in the setup cycle
   // ----------------------------------------------------------------
   logic [31:0] next_rdata;
   always_comb begin
      next_rdata = 32'h0000_0000;
      unique case (paddr)
         OFS_DATA:    next_rdata = (state == ST_IDENT) ?                // [RULE_07]
                                   {16'h0000, ident_word(ident_idx, card_mode)} : 32'h0;
         OFS_ERRFEAT: next_rdata = {24'h0, err_reg};
         OFS_SECCNT:  next_rdata = {24'h0, sec_cnt};
         OFS_SECNUM:  next_rdata = {24'h0, sec_num};
         OFS_CYLLO:   next_rdata = {24'h0, cyl_lo};
         OFS_CYLHI:   next_rdata = {24'h0, cyl_hi};
         OFS_DRVHEAD: next_rdata = {24'h0, drv_head};
         OFS_STATCMD: next_rdata = {24'h0, status};
         OFS_ALTCTL:  next_rdata = {24'h0, status};
         OFS_CONFIG:  next_rdata = {28'h0, pwr, card_mode, dma_en};
         default:     next_rdata = 32'h0000_0000;
      endcase
   end

   // Zero wait states keep the read side effects tied to the access phase
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         prdata <= 32'h0000_0000;
      end else if (ce && setup_rd) begin
         prdata <= next_rdata;
      end
   end

   assign pready  = 1'b1;
   assign pslverr = acc && !mapped;
endmodule : aci_top

// File: test/aci_host.sv
// Host controller model: APB master reaching the task-file registers
`timescale 1ns/10ps
module aci_host (
   input  wire logic        sys_clk,
   input  wire logic        pready,
   input  wire logic [31:0] prdata,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata
);
   initial begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'hff;
      pwdata  = 32'h0;
   end
   // Request held until pready is sampled high, then released
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      @(posedge sys_clk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      q = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
      // Released lines flip so a stale value is never mistaken for a request
      paddr   <= ~a;
      pwdata  <= ~d;
   endtask : xfer
endmodule : aci_host

// File: test/aci_sva.sv
// Port assertions for the ATA command interpreter
`timescale 1ns/10ps
module aci_sva
   import aci_pkg::*;
(
   input wire logic        sys_clk,
   input wire logic        rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pslverr,
   input wire logic        busy_flag,
   input wire logic        host_irq_request
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   logic       drv_r, dma_r;
   wire        acc  = psel && penable;
   wire        wacc = acc && pwrite;
   wire        srst = wacc && paddr == OFS_ALTCTL && pwdata[BIT_SRST];
   wire        cmd  = wacc && paddr == OFS_STATCMD && !busy_flag && !drv_r;
   wire  [7:0] op   = pwdata[7:0];
   // Shadows follow only writes the device accepts, so refused ones do not mislead
   always_ff @(posedge sys_clk) begin
      if (rst || srst) drv_r <= 1'b0;
      else if (wacc && paddr == OFS_DRVHEAD && !busy_flag) drv_r <= pwdata[BIT_DRIVE];
      if (rst || srst) dma_r <= 1'b0;
      else if (wacc && paddr == OFS_CONFIG) dma_r <= pwdata[BIT_DMA_EN];
   end
   power_query_a: assert property (
      cmd && (op == OP_CHKPWR_A || op == OP_CHKPWR_B) |=> busy_flag ##1 !busy_flag)
      else $error("power query busy length wrong");
   diag_len_a: assert property (
      cmd && op == OP_DIAG |=> busy_flag ##31 busy_flag ##1 !busy_flag)
      else $error("diagnostic busy length wrong");
   sleep_cmd_a: assert property (
      cmd && (op == OP_SLEEP_A || op == OP_SLEEP_B) |=> !busy_flag ##1 host_irq_request)
      else $error("sleep command not completed");
   standby_cmd_a: assert property (
      cmd && (op == OP_STBY_A || op == OP_STBY_B) |=> !busy_flag ##1 host_irq_request)
      else $error("standby command not completed");
   dma_off_a: assert property (
      cmd && !dma_r && (op == OP_RD_DMA || op == OP_WR_DMA) |=> !busy_flag ##1 host_irq_request)
      else $error("disabled transfer opcode accepted");
   drive_sel_a: assert property (
      wacc && paddr == OFS_STATCMD && !busy_flag && drv_r
      |=> (!busy_flag && !$rose(host_irq_request)) [*3])
      else $error("command for other drive executed");
   irq_order_a: assert property (
      $fell(busy_flag) && !$past(srst) |-> !host_irq_request ##1 host_irq_request)
      else $error("interrupt not one cycle after busy");
   status_clear_a: assert property (
      acc && !pwrite && paddr == OFS_STATCMD && host_irq_request && !busy_flag
      |=> !host_irq_request)
      else $error("status read left interrupt pending");
   unmapped_err_a: assert property (
      acc |-> pslverr == (paddr > OFS_CONFIG || paddr[1:0] != 2'b00))
      else $error("unmapped access not flagged");
   ident_cov: cover property (cmd && op == OP_IDENT);
   diag_cov: cover property (cmd && op == OP_DIAG);
   done_cov: cover property ($fell(busy_flag));
endmodule : aci_sva

// File: test/aci_top_test.sv
// Self-checking testbench for the ATA command interpreter
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin err_total++; \
   $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module aci_top_test
   import aci_pkg::*;
;
   logic        sys_clk, rst, ce, psel, penable, pwrite, pready, pslverr;
   logic        busy_flag, host_irq_request;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, q;
   int          err_total = 0;
   int          checked = 0;
   int          nbusy, irq_seen;
   aci_top #(.LBA_TOTAL(32'h0001_0000), .BUF_BLOCKS(16'h0002), .DRIVE_NUM(1'b0)) dut (
      .sys_clk(sys_clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .busy_flag(busy_flag), .host_irq_request(host_irq_request));
   aci_host host (.sys_clk(sys_clk), .pready(pready), .prdata(prdata), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      host.xfer(1'b1, a, {24'h0, d}, q);
   endtask : wr
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      host.xfer(1'b0, a, 32'h0, q);
      `CHK("reg", e, q[7:0])
   endtask : rchk
   // Counts busy cycles, watches for the interrupt, then reads status into q
   task automatic finish_cmd();
      nbusy = 0;
      irq_seen = 0;
      @(negedge sys_clk);
      while (busy_flag === 1'b1 && nbusy < 400) begin
         nbusy++;
         @(negedge sys_clk);
      end
      repeat (3) begin
         if (host_irq_request === 1'b1) irq_seen = 1;
         @(negedge sys_clk);
      end
      host.xfer(1'b0, OFS_STATCMD, 32'h0, q);
   endtask : finish_cmd
   task automatic run(input logic [7:0] op);
      wr(OFS_STATCMD, op);
      finish_cmd();
   endtask : run
   task automatic t_power();
      logic [7:0] ops [8];
      ops = '{OP_SLEEP_A, OP_IDLE_A, OP_SLEEP_B, OP_IDLI_A, OP_STBY_A, OP_IDLE_B,
              OP_STBY_B, OP_IDLI_B};
      rchk(OFS_DRVHEAD, RST_DRVHEAD);
      wr(OFS_DRVHEAD, 8'h4f); // Head and mode bits set, select bit clear
      run(OP_CHKPWR_A);
      `CHK("busy", 1, nbusy)
      `CHK("irq", 1, irq_seen)
      @(negedge sys_clk);
      `CHK("irq clear", 1'b0, host_irq_request)
      rchk(OFS_SECCNT, PWR_IDLE_CODE);
      for (int i = 0; i < 8; i++) begin
         run(ops[i]);
         `CHK("irq", 1, irq_seen)
         run(i % 2 ? OP_CHKPWR_A : OP_CHKPWR_B);
         rchk(OFS_SECCNT, i % 2 ? PWR_IDLE_CODE : PWR_STANDBY_CODE);
      end
   endtask : t_power
   task automatic t_media();
      logic [7:0] ops [8];
      ops = '{OP_RD_A, OP_RD_B, OP_VFY_A, OP_VFY_B, OP_WR_A, OP_WR_B, OP_RDL_A, OP_RDL_B};
      run(OP_DIAG);
      `CHK("busy", 32, nbusy)
      rchk(OFS_ERRFEAT, DIAG_PASS_CODE);
      for (int i = 0; i < 8; i++) begin
         wr(OFS_SECCNT, 8'h01);
         run(ops[i]);
         `CHK("busy", MEDIA_CYCLES + 1, nbusy)
         `CHK("err", 1'b0, q[BIT_ERR])
      end
      wr(OFS_SECCNT, 8'h04);
      run(OP_FORMAT);
      `CHK("busy", 5, nbusy)
      wr(OFS_SECCNT, 8'h00);
      run(OP_FORMAT);
      `CHK("busy", 257, nbusy)
      wr(OFS_SECCNT, 8'h02);
      wr(OFS_STATCMD, OP_RD_A);
      wr(OFS_STATCMD, 8'hff); // Unknown opcode sent while busy must be dropped
      finish_cmd();
      `CHK("err", 1'b0, q[BIT_ERR])
   endtask : t_media
   task automatic t_abort();
      run(8'hff);
      `CHK("err", 1'b1, q[BIT_ERR])
      `CHK("irq", 1, irq_seen)
      host.xfer(1'b0, OFS_ERRFEAT, 32'h0, q);
      `CHK("abort", 1'b1, q[BIT_ABORT])
      wr(OFS_CONFIG, 8'h00);
      run(OP_RD_DMA);
      `CHK("err", 1'b1, q[BIT_ERR])
      run(OP_WR_DMA);
      `CHK("err", 1'b1, q[BIT_ERR])
      wr(OFS_CONFIG, 8'h01);
      wr(OFS_SECCNT, 8'h01);
      run(OP_RD_DMA);
      `CHK("busy", MEDIA_CYCLES + 1, nbusy)
      wr(OFS_DRVHEAD, 8'hb0);
      run(OP_CHKPWR_A);
      `CHK("busy", 0, nbusy)
      `CHK("irq", 0, irq_seen)
      wr(OFS_DRVHEAD, RST_DRVHEAD);
   endtask : t_abort
   task automatic t_ident();
      for (int m = 0; m < 2; m++) begin
         wr(OFS_CONFIG, m ? 8'h02 : 8'h00);
         wr(OFS_STATCMD, OP_IDENT);
         for (int w = 0; w < IDENT_WORDS; w++) begin
            host.xfer(1'b0, OFS_DATA, 32'h0, q);
            if (w == 0) `CHK("w0", m ? ID_W0_REMOVABLE : ID_W0_FIXED, q[15:0])
            if (w == 20) `CHK("w20", 16'h0002, q[15:0])
            if (w == 21) `CHK("w21", 16'h0002, q[15:0])
            if (w == 22) `CHK("w22", 16'h0004, q[15:0])
            if (w == 47) `CHK("w47", 8'h01, q[7:0])
            if (w == 51) `CHK("w51", 8'h01, q[15:8])
            if (w == 60) `CHK("w60", 16'h0000, q[15:0])
            if (w == 61) `CHK("w61", 16'h0001, q[15:0])
         end
         finish_cmd();
         `CHK("irq", 1, irq_seen)
      end
   endtask : t_ident
   task automatic wrap_up();
      $display("checked %0d err_total %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : wrap_up
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      err_total++;
      wrap_up();
   end
   initial begin
      rst = 1'b1;
      ce  = 1'b1;
      repeat (10) @(posedge sys_clk);
      rst <= 1'b0;
      rchk(OFS_SECCNT, RST_SECCNT);
      rchk(8'h28, 8'h00);
      t_power();
      t_media();
      t_abort();
      t_ident();
      wrap_up();
   end
endmodule : aci_top_test
bind aci_top aci_sva chk (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr), .busy_flag(busy_flag),
   .host_irq_request(host_irq_request));
